/* hw/bcl_consts.vh */
// Constants for the boot configuration loader.
// Assumes inclusion by bare name from the design files.
`ifndef BCL_CONSTS_VH
`define BCL_CONSTS_VH
`define BCL_CLK_MHZ          50
`define BCL_WAKE_NS          30000
`define BCL_WAKE_CYC         ((`BCL_WAKE_NS * `BCL_CLK_MHZ + 999) / 1000)
`define BCL_OP_WAKE          8'hAB
`define BCL_OP_FREAD         8'h0B
`define BCL_START_ADDR       24'h00_0000
`define BCL_DUMMY_BITS       8
`define BCL_MODE_ACTIVE      2'h0
`define BCL_MODE_PASSIVE     2'h1
`define BCL_MODE_SCAN        2'h2
`define BCL_SCLK_DIV         4
`define BCL_FIFO_DEPTH       8
`endif

/* hw/bcl_fifo.v */
// Small synchronous FIFO between bit assembly and configuration memory write.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/10ps
`default_nettype none
module bcl_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,
    input  wire             srst_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
        if (srst_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* hw/bcl_loader.v */
// Boot configuration loader: fills configuration memory from flash,
// an external master or the test port, then releases user mode.
// Assumes config_reset_n, passive and scan pins are asynchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "bcl_consts.vh"
module bcl_loader #(
    parameter WORD_W    = 32,
    parameter AW        = 16,
    parameter LEN_WORDS = 16'h0100,
    parameter WAKE_CYC  = `BCL_WAKE_CYC
) (
    input  wire              clk_i,
    input  wire              srst_i,
    input  wire              config_reset_n_i,
    input  wire [1:0]        mode_i,
    input  wire [5:0]        width_i,
    input  wire [3:0]        flash_dq_i,
    output reg  [3:0]        flash_dq_o,
    output reg  [3:0]        flash_dq_oe_o,
    output reg               flash_sclk_o,
    output reg               flash_cs_n_o,
    input  wire              pas_clk_i,
    input  wire              pas_cs_n_i,
    input  wire [31:0]       pas_data_i,
    input  wire              tck_i,
    input  wire              tdi_i,
    output reg               cfg_we_o,
    output reg  [AW-1:0]     cfg_addr_o,
    output reg  [WORD_W-1:0] cfg_data_o,
    output reg               user_mode_o,
    output reg               width_err_o
);
    localparam S_IDLE = 3'd0;
    localparam S_WAKE = 3'd1;
    localparam S_WAIT = 3'd2;
    localparam S_CMD  = 3'd3;
    localparam S_DUMY = 3'd4;
    localparam S_DATA = 3'd5;
    localparam S_DRN  = 3'd6;
    localparam S_DONE = 3'd7;
    localparam [7:0]   OP_WAKE  = `BCL_OP_WAKE;
    localparam [7:0]   OP_FREAD = `BCL_OP_FREAD;
    localparam integer DUMMY_N  = `BCL_DUMMY_BITS;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every asynchronous input
    reg [36:0] s1_q;
    reg [36:0] s2_q;
    always @(posedge clk_i) begin
        s1_q <= {config_reset_n_i, pas_clk_i, pas_cs_n_i, tck_i, tdi_i, pas_data_i};
        s2_q <= s1_q;
    end
    wire        rst_n_s = s2_q[36];
    wire        pclk_s  = s2_q[35];
    wire        pcs_n_s = s2_q[34];
    wire        tck_s   = s2_q[33];
    wire        tdi_s   = s2_q[32];
    wire [31:0] pdat_s  = s2_q[31:0];
    reg         rst_n_q;
    reg         pclk_q;
    reg         tck_q;
    always @(posedge clk_i) begin
        rst_n_q <= rst_n_s;
        pclk_q  <= pclk_s;
        tck_q   <= tck_s;
    end
    wire start   = rst_n_s && !rst_n_q;
    wire prise   = pclk_s && !pclk_q;
    wire trise   = tck_s && !tck_q;

    ////////////////////////////////////////////////////////////////////////////
    // Mode and width check, latched at start
    reg [1:0] mode_q;
    reg [5:0] wid_q;
    reg       wid_ok;
    always @* begin
        case (mode_i)
            `BCL_MODE_ACTIVE:  wid_ok = (width_i == 6'd1) || (width_i == 6'd2) ||
                                        (width_i == 6'd4);
            `BCL_MODE_PASSIVE: wid_ok = (width_i == 6'd1) || (width_i == 6'd2) ||
                                        (width_i == 6'd4) || (width_i == 6'd8) ||
                                        (width_i == 6'd16) || (width_i == 6'd32);
            `BCL_MODE_SCAN:    wid_ok = (width_i == 6'd1);
            default:           wid_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal serial clock divider; it is the only source of the flash clock
    reg [7:0]  div_q;
    wire       tick = (div_q == `BCL_SCLK_DIV - 1);
    reg [2:0]  st_q;
    reg [15:0] wait_q;
    reg [5:0]  bit_q;
    reg [31:0] sh_q;
    reg [31:0] acc_q;
    reg [5:0]  fill_q;
    reg        push_q;
    reg [AW-1:0] words_q;
    wire       fifo_rdy;
    wire       fifo_vld;
    wire [WORD_W-1:0] fifo_dat;
    // Passive and test-port loads must leave the flash clock still
    wire       flash_run = (st_q == S_WAKE) || (st_q == S_CMD) || (st_q == S_DUMY) ||
                           ((st_q == S_DATA) && (mode_q == `BCL_MODE_ACTIVE));

    // Input sample for the current mode and width, LSB-aligned
    reg        samp_en;
    reg [31:0] samp_bits;
    always @* begin
        samp_en   = 1'b0;
        samp_bits = 32'h0000_0000;
        case (mode_q)
            `BCL_MODE_ACTIVE: begin
                samp_en   = (st_q == S_DATA) && tick && flash_sclk_o && fifo_rdy;
                samp_bits = (wid_q == 6'd1) ? {31'h0000_0000, flash_dq_i[1]} :
                            {28'h000_0000, flash_dq_i};
            end
            `BCL_MODE_PASSIVE: begin
                samp_en   = (st_q == S_DATA) && prise && !pcs_n_s;
                samp_bits = pdat_s;
            end
            `BCL_MODE_SCAN: begin
                samp_en   = (st_q == S_DATA) && trise;
                samp_bits = {31'h0000_0000, tdi_s};
            end
            default: begin
                samp_en   = 1'b0;
                samp_bits = 32'h0000_0000;
            end
        endcase
    end

    // Mask selects the bits of the active width
    wire [31:0] wmask = (wid_q == 6'd32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << wid_q) - 1'b1);
    wire [5:0]  nfill = fill_q + wid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always @(posedge clk_i) begin
        if (srst_i) begin
            st_q          <= S_IDLE;
            div_q         <= 8'h00;
            wait_q        <= 16'h0000;
            bit_q         <= 6'd0;
            sh_q          <= 32'h0000_0000;
            acc_q         <= 32'h0000_0000;
            fill_q        <= 6'd0;
            push_q        <= 1'b0;
            words_q       <= {AW{1'b0}};
            mode_q        <= `BCL_MODE_ACTIVE;
            wid_q         <= 6'd1;
            flash_sclk_o  <= 1'b0;
            flash_cs_n_o  <= 1'b1;
            flash_dq_o    <= 4'h0;
            flash_dq_oe_o <= 4'h0;
            user_mode_o   <= 1'b0;
            width_err_o   <= 1'b0;
        end else begin
            div_q  <= tick ? 8'h00 : div_q + 8'h01;
            push_q <= 1'b0;
            if (tick && flash_run && !(st_q == S_DATA && !fifo_rdy && flash_sclk_o)) begin
                flash_sclk_o <= !flash_sclk_o;
            end
            if (samp_en) begin
                acc_q  <= acc_q | ((samp_bits & wmask) << (WORD_W - nfill));
                fill_q <= nfill;
                if (nfill == 6'd32) begin
                    push_q <= 1'b1;
                    fill_q <= 6'd0;
                end
            end
            if (push_q) begin
                acc_q   <= 32'h0000_0000;
                words_q <= words_q + 1'b1;
            end
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        user_mode_o <= 1'b0;
                        mode_q      <= mode_i;
                        wid_q       <= width_i;
                        width_err_o <= !wid_ok;
                        words_q     <= {AW{1'b0}};
                        fill_q      <= 6'd0;
                        acc_q       <= 32'h0000_0000;
                        if (wid_ok) begin
                            if (mode_i == `BCL_MODE_ACTIVE) begin
                                st_q          <= S_WAKE;
                                sh_q          <= {`BCL_OP_WAKE, 24'h00_0000};
                                bit_q         <= 6'd8;
                                flash_cs_n_o  <= 1'b0;
                                flash_dq_oe_o <= 4'h1;
                                flash_dq_o    <= {3'b000, OP_WAKE[7]};
                            end else begin
                                st_q <= S_DATA;
                            end
                        end
                    end
                end
                S_WAKE, S_CMD: begin
                    if (tick && flash_sclk_o) begin
                        sh_q       <= {sh_q[30:0], 1'b0};
                        flash_dq_o <= {3'b000, sh_q[30]};
                        bit_q      <= bit_q - 6'd1;
                        if (bit_q == 6'd1) begin
                            flash_dq_oe_o <= 4'h0;
                            if (st_q == S_WAKE) begin
                                st_q         <= S_WAIT;
                                flash_cs_n_o <= 1'b1;
                                wait_q       <= 16'h0000;
                            end else begin
                                st_q  <= S_DUMY;
                                bit_q <= DUMMY_N[5:0];
                            end
                        end
                    end
                end
                S_WAIT: begin
                    // Saturate and wait for the next tick, so any nonzero 16-bit wait length works
                    if (wait_q != WAKE_CYC[15:0]) begin
                        wait_q <= wait_q + 16'h0001;
                    end
                    if (wait_q >= WAKE_CYC[15:0] - 16'h0001 && tick) begin
                        st_q          <= S_CMD;
                        sh_q          <= {`BCL_OP_FREAD, `BCL_START_ADDR};
                        bit_q         <= 6'd32;
                        flash_cs_n_o  <= 1'b0;
                        flash_dq_oe_o <= 4'h1;
                        flash_dq_o    <= {3'b000, OP_FREAD[7]};
                    end
                end
                S_DUMY: begin
                    if (tick && flash_sclk_o) begin
                        bit_q <= bit_q - 6'd1;
                        if (bit_q == 6'd1) begin
                            st_q <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (push_q && words_q == LEN_WORDS[AW-1:0] - 1'b1) begin
                        st_q         <= S_DRN;
                        flash_cs_n_o <= 1'b1;
                    end
                end
                S_DRN: begin
                    if (!fifo_vld) begin
                        st_q        <= S_DONE;
                        user_mode_o <= 1'b1;
                    end
                end
                S_DONE: begin
                    if (start) begin
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
            if (!rst_n_s) begin
                st_q          <= S_IDLE;
                user_mode_o   <= 1'b0;
                flash_cs_n_o  <= 1'b1;
                flash_sclk_o  <= 1'b0;
                flash_dq_oe_o <= 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word buffer and configuration memory write port
    reg [AW-1:0] waddr_q;
    always @(posedge clk_i) begin
        if (srst_i || start) begin
            cfg_we_o   <= 1'b0;
            cfg_addr_o <= {AW{1'b0}};
            cfg_data_o <= {WORD_W{1'b0}};
            waddr_q    <= {AW{1'b0}};
        end else begin
            cfg_we_o <= fifo_vld;
            if (fifo_vld) begin
                cfg_data_o <= fifo_dat;
                cfg_addr_o <= waddr_q;
                waddr_q    <= waddr_q + 1'b1;
            end
        end
    end

    bcl_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (`BCL_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_data_i   (acc_q),
        .in_valid_i  (push_q),
        .in_ready_o  (fifo_rdy),
        .out_data_o  (fifo_dat),
        .out_valid_o (fifo_vld),
        .out_ready_i (1'b1)
    );
endmodule
`default_nettype wire

/* verification/bcl_flash_model.sv */
// Behavioural serial flash on the far side of the active configuration port.
// Assumes the loader clocks it and samples data on falling flash clock edges; commands are taken on rising edges.
`timescale 1ns/10ps
`default_nettype none
module bcl_flash_model (
    input  wire logic        rst_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  dq_i,
    input  wire logic [5:0]  width_i,
    output logic      [3:0]  dq_o,
    output logic      [7:0]  first_op_o,
    output logic      [7:0]  op_o,
    output logic      [23:0] addr_o
);
    int          nb = 0;
    int          frames = 0;
    int          k;
    logic [31:0] sh = '0;
    function automatic bit sbit(input int b);
        logic [7:0] v;
        v = 8'(b >> 3) * 8'h1D ^ 8'hA5;
        return v[7 - (b & 7)];
    endfunction
    initial dq_o = 4'h0;
    always @(posedge rst_i) frames = 0;
    // Released lines show the inverse, so a stale value never passes
    // Reset drives select high, which is not the end of a frame
    always @(posedge cs_n_i) begin
        if (!rst_i) frames++;
        dq_o = ~dq_o;
    end
    always @(negedge cs_n_i) nb = 0;
    always @(posedge sclk_i) if (!cs_n_i) begin
        sh = {sh[30:0], dq_i[0]};
        nb++;
        if (nb == 8 && frames == 0) first_op_o = sh[7:0];
        if (nb == 32) {op_o, addr_o} = sh;
    end
    // Data after opcode, address and dummy bits, first bit on the top lane
    always @(negedge sclk_i) if (!cs_n_i && nb >= 40) begin
        k = (nb - 40) * width_i;
        if (width_i == 1) dq_o[1] = sbit(k);
        else for (int i = 0; i < width_i; i++) dq_o[width_i - 1 - i] = sbit(k + i);
    end
endmodule
`default_nettype wire

/* verification/bcl_loader_chk.sv */
// Timing checks on the loader's ports.
// Assumes a bind onto bcl_loader with its parameters passed on.
`timescale 1ns/10ps
`default_nettype none
`include "bcl_consts.vh"
module bcl_loader_chk #(
    parameter int AW        = 16,
    parameter int LEN_WORDS = 256,
    parameter int WAKE_CYC  = 1500
) (
    input wire logic          clk_i,
    input wire logic          srst_i,
    input wire logic          config_reset_n_i,
    input wire logic [1:0]    mode_i,
    input wire logic [5:0]    width_i,
    input wire logic [3:0]    flash_dq_oe_o,
    input wire logic          flash_sclk_o,
    input wire logic          flash_cs_n_o,
    input wire logic          cfg_we_o,
    input wire logic [AW-1:0] cfg_addr_o,
    input wire logic          user_mode_o,
    input wire logic          width_err_o
);
    logic [16:0] words_q;
    logic [15:0] gap_q;
    logic [1:0]  frames_q;
    always @(posedge clk_i) begin
        if (srst_i || !config_reset_n_i) begin
            words_q <= '0;
            frames_q <= '0;
        end else begin
            if (cfg_we_o) words_q <= words_q + 17'h1;
            if ($rose(flash_cs_n_o) && frames_q != 2'h3) frames_q <= frames_q + 2'h1;
        end
        // Saturates so a long idle never wraps into a short gap
        if (srst_i || !flash_cs_n_o) gap_q <= '0;
        else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    chk_user_after_load: assert property ($rose(user_mode_o) |-> words_q == LEN_WORDS)
        else $error("user mode before full load");
    chk_no_write_user: assert property (user_mode_o |-> !cfg_we_o)
        else $error("memory write in user mode");
    chk_start_on_rise: assert property ($rose(config_reset_n_i) && mode_i == `BCL_MODE_ACTIVE
        && width_i == 6'd1 |-> ##[1:8] !flash_cs_n_o) else $error("no flash select after start");
    chk_width_refuse: assert property ($rose(config_reset_n_i) && width_i == 6'd8
        && mode_i == `BCL_MODE_ACTIVE |-> ##[1:8] width_err_o) else $error("bad width accepted");
    chk_passive_quiet: assert property (mode_i != `BCL_MODE_ACTIVE
        |-> flash_cs_n_o && flash_dq_oe_o == 4'h0) else $error("flash driven outside active mode");
    chk_sclk_high: assert property ($rose(flash_sclk_o) |-> flash_sclk_o[*4])
        else $error("flash clock high phase short");
    chk_wake_gap: assert property ($fell(flash_cs_n_o) && frames_q == 2'h1
        |-> gap_q >= WAKE_CYC) else $error("wake wait too short");
    chk_sclk_idle: assert property (flash_cs_n_o && $past(flash_cs_n_o)
        |-> $stable(flash_sclk_o)) else $error("flash clock runs outside frame");
    chk_addr_order: assert property (cfg_we_o |-> cfg_addr_o == words_q[AW-1:0])
        else $error("memory address out of order");
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the loader: active loads from the flash model,
// passive and test-port loads driven here, and refused widths.
`timescale 1ns/10ps
`default_nettype none
`include "bcl_consts.vh"
module testbench;
    localparam int LEN = 4;
    logic clk_i = 0, srst_i = 1, crn = 0, pas_clk = 0, pas_cs_n = 1, tck = 0, tdi = 0;
    logic [1:0] mode = 0;
    logic [5:0] width = 1;
    logic [31:0] pas_data = 0, got[LEN], exp[LEN];
    logic [3:0] dq_o, dq_oe, dq_m, dq_w;
    logic sclk, cs_n, we, user, werr;
    logic [15:0] addr;
    logic [31:0] data;
    logic [7:0] fop, op;
    logic [23:0] faddr;
    int err_count = 0, total_checks = 0, nwr;
    logic [5:0] aw[3] = '{1, 2, 4};
    logic [7:0] tbl[7] = '{8'h41, 8'h42, 8'h44, 8'h48, 8'h50, 8'h60, 8'h81};
    logic [7:0] bad[4] = '{8'h08, 8'h82, 8'h43, 8'hC1};
    always #10 clk_i = ~clk_i;
    assign dq_w = (dq_oe & dq_o) | (~dq_oe & dq_m);
    bcl_loader #(.LEN_WORDS(16'(LEN)), .WAKE_CYC(20)) i_dut (.clk_i(clk_i), .srst_i(srst_i),
        .config_reset_n_i(crn), .mode_i(mode), .width_i(width), .flash_dq_i(dq_w),
        .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe), .flash_sclk_o(sclk), .flash_cs_n_o(cs_n),
        .pas_clk_i(pas_clk), .pas_cs_n_i(pas_cs_n), .pas_data_i(pas_data), .tck_i(tck),
        .tdi_i(tdi), .cfg_we_o(we), .cfg_addr_o(addr), .cfg_data_o(data),
        .user_mode_o(user), .width_err_o(werr));
    bcl_flash_model i_flash (.rst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .dq_i(dq_w),
        .width_i(width), .dq_o(dq_m), .first_op_o(fop), .op_o(op), .addr_o(faddr));
    always @(posedge clk_i) begin
        if (srst_i) nwr <= 0;
        else if (we === 1'b1) begin
            got[addr[1:0]] <= data;
            nwr <= nwr + 1;
        end
    end
    function automatic logic [7:0] fb(input int a);
        return 8'(a) * 8'h1D ^ 8'hA5;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Mode and width change only under reset, so every load starts clean
    task automatic start(input logic [1:0] m, input logic [5:0] w);
        srst_i <= 1;
        crn <= 0;
        mode <= m;
        width <= w;
        repeat (5) @(posedge clk_i);
        srst_i <= 0;
        repeat (4) @(posedge clk_i);
        crn <= 1;
        repeat (2) @(posedge clk_i);
        chk({31'h0, user}, 32'h0);
    endtask
    task automatic wait_done;
        int i;
        for (i = 0; i < 30000 && user !== 1'b1 && werr !== 1'b1; i++) @(posedge clk_i);
        if (i == 30000) begin
            err_count++;
            $display("MISMATCH t=%0t load never finished", $time);
            report_and_stop;
        end
        repeat (2) @(posedge clk_i);
    endtask
    task automatic compare;
        for (int n = 0; n < LEN; n++) chk(got[n], exp[n]);
        chk(32'(nwr), LEN);
        chk({31'h0, user}, 32'h1);
    endtask
    // One link clock period of 160 ns; the clock stands still between frames
    task automatic edge_out(input logic [31:0] d, input bit scan);
        pas_data <= d;
        tdi <= d[0];
        repeat (4) @(posedge clk_i);
        if (scan) tck <= 1;
        else pas_clk <= 1;
        repeat (4) @(posedge clk_i);
        tck <= 0;
        pas_clk <= 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [63:0] m;
        logic [5:0] w;
        int s;
        s = $urandom(67835);
        foreach (aw[i]) begin
            start(`BCL_MODE_ACTIVE, aw[i]);
            for (int n = 0; n < LEN; n++) exp[n] = {fb(4*n), fb(4*n+1), fb(4*n+2), fb(4*n+3)};
            wait_done;
            chk({24'h0, fop}, {24'h0, `BCL_OP_WAKE});
            chk({op, faddr}, {`BCL_OP_FREAD, `BCL_START_ADDR});
            compare;
        end
        foreach (tbl[i]) begin
            w = tbl[i][5:0];
            start(tbl[i][7:6], w);
            m = (64'h1 << w) - 64'h1;
            pas_cs_n <= 0;
            for (int n = 0; n < LEN; n++) begin
                exp[n] = $urandom;
                for (int e = 0; e < 32 / w; e++)
                    edge_out(($urandom & ~m[31:0]) | ((exp[n] >> (32 - w*(e+1))) & m[31:0]),
                        tbl[i][7]);
            end
            pas_cs_n <= 1;
            wait_done;
            compare;
        end
        foreach (bad[i]) begin
            start(bad[i][7:6], bad[i][5:0]);
            wait_done;
            chk({30'h0, werr, user}, 32'h2);
            chk(32'(nwr), 32'h0);
        end
        report_and_stop;
    end
endmodule
bind bcl_loader bcl_loader_chk #(.AW(AW), .LEN_WORDS(LEN_WORDS), .WAKE_CYC(WAKE_CYC)) i_chk (
    .clk_i(clk_i), .srst_i(srst_i), .config_reset_n_i(config_reset_n_i), .mode_i(mode_i),
    .width_i(width_i), .flash_dq_oe_o(flash_dq_oe_o), .flash_sclk_o(flash_sclk_o),
    .flash_cs_n_o(flash_cs_n_o), .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o),
    .user_mode_o(user_mode_o), .width_err_o(width_err_o));
`default_nettype wire
